//--- logic/acc_bank.sv
// Purpose: indexed working accumulators
// Assumes: register transfer and alu result may hit the same entry
// Notes:   operand is the selected entry as it will stand after this edge
`timescale 1ns/10ps
module acc_bank #(
  parameter int DATA_W    = 16,
  parameter int ACC_COUNT = 16,
  parameter int IDX_W     = 4
) (
  input  wire logic  core_clk,
  input  wire logic  reset_n,
  acc_bank_if.bank   bus
);
  logic [ACC_COUNT-1:0][DATA_W-1:0] acc;
  logic [ACC_COUNT-1:0][DATA_W-1:0] next_acc;

  // ==========================================================
  // next state: register transfer wins over alu writeback
  always_comb
  begin
    next_acc = acc;
    if (bus.alu_en)
      next_acc[bus.sel] = bus.alu_data;
    if (bus.wr_en)
      next_acc[bus.wr_index] = bus.wr_data;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      acc <= '0;
    else
      acc <= next_acc;
  end

  assign bus.rd_data = acc[bus.rd_index];
  assign bus.operand = next_acc[bus.sel];

  // ==========================================================
  // checks
  reset_clear_a: assert property (@(posedge core_clk) !reset_n |-> acc == '0)
    else $error("accumulators not zero in reset");
  reg_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    bus.wr_en |=> acc[$past(bus.wr_index)] == $past(bus.wr_data))
    else $error("register write lost");
  alu_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    bus.alu_en && !(bus.wr_en && bus.wr_index == bus.sel)
      |=> acc[$past(bus.sel)] == $past(bus.alu_data))
    else $error("alu result lost");
endmodule // acc_bank

//--- logic/acc_bank_if.sv
// Purpose: carrier between the register control and the accumulator bank
// Assumes: one clock, same domain on both sides
// Notes:   rd_data and operand are combinational from the bank
`timescale 1ns/10ps
interface acc_bank_if #(
  parameter int DATA_W = 16,
  parameter int IDX_W  = 4
);
  logic              wr_en;
  logic [IDX_W-1:0]  wr_index;
  logic [DATA_W-1:0] wr_data;
  logic              alu_en;
  logic [IDX_W-1:0]  sel;
  logic [DATA_W-1:0] alu_data;
  logic [IDX_W-1:0]  rd_index;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] operand;
  modport ctrl (output wr_en, wr_index, wr_data, alu_en, sel, alu_data, rd_index,
                input  rd_data, operand);
  modport bank (input  wr_en, wr_index, wr_data, alu_en, sel, alu_data, rd_index,
                output rd_data, operand);
endinterface // acc_bank_if

//--- logic/acc_prefix_pkg.sv
// Purpose: shared constants of the accumulator and prefix register block
// Assumes: register transfers address a module code and an index
// Notes:   all numbers used by the design live here
package acc_prefix_pkg;
  // ==========================================================
  // register module codes
  localparam logic [3:0]  ACC_MODULE      = 4'h9;
  localparam logic [3:0]  PREFIX_MODULE   = 4'hb;
  // ==========================================================
  // widths and counts
  localparam int          WIDE_W          = 16;
  localparam int          NARROW_W        = 8;
  localparam int          PREFIX_W        = 16;
  localparam int          PREFIX_USED_W   = 8;
  localparam int          INDEX_W         = 4;
  localparam int          ACC_COUNT       = 16;
  // ==========================================================
  // reset values
  localparam logic [15:0] ACC_RESET       = 16'h0000;
  localparam logic [15:0] PREFIX_RESET    = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED   = 16'h0000;
  // ==========================================================
  // prefix index that leaves both banks default or raises the source or destination bank
  localparam logic [3:0]  PFX_IDX_PLAIN   = 4'h0;
  localparam logic [3:0]  PFX_IDX_SRC_HI  = 4'h1;
  localparam logic [3:0]  PFX_IDX_DST_HI  = 4'h2;
  // ==========================================================
  // timing: prefix lives for one execution cycle
  localparam int          PREFIX_HOLD_CYCLES = 1;
endpackage

//--- logic/accumulator_prefix_registers.sv
// Purpose: working accumulators and the one-cycle instruction prefix word
// Assumes: one instruction executes per core_clk cycle; same-clock core logic
// Notes:   reads answer one cycle after the strobe
`timescale 1ns/10ps

// Functional notes
// - narrow variant: every accumulator clears to zero on any reset
// - wide variant: accumulators are 16 bits and clear to zero on reset
// - selected accumulator feeds and takes alu results; all are plain read/write
// - prefix word is 16 bits; only its low byte prefixes the next instruction
// - prefix word holds one cycle then returns to zero; zero after reset
// - every prefix index reads and writes the same 16-bit word
// - prefix write index sets next instruction source and destination banks
// - after the hold the banks fall back to default destinations 0h-7h
module accumulator_prefix_registers #(
  parameter int DATA_W    = acc_prefix_pkg::WIDE_W,
  parameter int ACC_COUNT = acc_prefix_pkg::ACC_COUNT
) (
  input  wire logic                                core_clk,
  input  wire logic                                reset_n,
  input  wire logic                                reg_wr,
  input  wire logic [3:0]                          reg_wr_module,
  input  wire logic [acc_prefix_pkg::INDEX_W-1:0]  reg_wr_index,
  input  wire logic [15:0]                         reg_wr_data,
  input  wire logic                                reg_rd,
  input  wire logic [3:0]                          reg_rd_module,
  input  wire logic [acc_prefix_pkg::INDEX_W-1:0]  reg_rd_index,
  output logic      [15:0]                         reg_rd_data,
  input  wire logic [acc_prefix_pkg::INDEX_W-1:0]  accumulator_selector,
  input  wire logic                                alu_result_valid,
  input  wire logic [DATA_W-1:0]                   alu_result,
  output logic      [DATA_W-1:0]                   alu_operand,
  output logic      [acc_prefix_pkg::PREFIX_USED_W-1:0] prefix_data,
  output logic                                     prefix_src_bank,
  output logic                                     prefix_dst_bank
);
  localparam int IDX_W = acc_prefix_pkg::INDEX_W;

  logic [acc_prefix_pkg::PREFIX_W-1:0] instruction_prefix_word;
  logic                                acc_wr;
  logic                                pfx_wr;
  logic [acc_prefix_pkg::PREFIX_W-1:0] pfx_wr_value;

  acc_bank_if #(.DATA_W(DATA_W), .IDX_W(IDX_W)) bank_bus ();

  // ==========================================================
  // write decode
  assign acc_wr       = reg_wr && (reg_wr_module == acc_prefix_pkg::ACC_MODULE);
  assign pfx_wr       = reg_wr && (reg_wr_module == acc_prefix_pkg::PREFIX_MODULE);
  assign pfx_wr_value = reg_wr_data;

  // ==========================================================
  // accumulator bank
  assign bank_bus.wr_en    = acc_wr;
  assign bank_bus.wr_index = reg_wr_index;
  assign bank_bus.wr_data  = reg_wr_data[DATA_W-1:0];
  assign bank_bus.alu_en   = alu_result_valid;
  assign bank_bus.sel      = accumulator_selector;
  assign bank_bus.alu_data = alu_result;
  assign bank_bus.rd_index = reg_rd_index;

  acc_bank #(
    .DATA_W    (DATA_W),
    .ACC_COUNT (ACC_COUNT),
    .IDX_W     (IDX_W)
  ) acc_bank_i (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .bus      (bank_bus.bank)
  );

  // operand tracks the selected accumulator including this edge's writes
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      alu_operand <= acc_prefix_pkg::ACC_RESET[DATA_W-1:0];
    else
      alu_operand <= bank_bus.operand;
  end

  // ==========================================================
  // prefix word: one shared register, lives for one cycle
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      instruction_prefix_word <= acc_prefix_pkg::PREFIX_RESET;
    else if (pfx_wr)
      instruction_prefix_word <= pfx_wr_value;
    else
      instruction_prefix_word <= acc_prefix_pkg::PREFIX_RESET;
  end

  // low byte only is passed on to the next instruction
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      prefix_data <= acc_prefix_pkg::PREFIX_RESET[acc_prefix_pkg::PREFIX_USED_W-1:0];
    else if (pfx_wr)
      prefix_data <= pfx_wr_value[acc_prefix_pkg::PREFIX_USED_W-1:0];
    else
      prefix_data <= acc_prefix_pkg::PREFIX_RESET[acc_prefix_pkg::PREFIX_USED_W-1:0];
  end

  // ==========================================================
  // register bank extension from the prefix write index
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prefix_src_bank <= 1'b0;
      prefix_dst_bank <= 1'b0;
    end
    else if (pfx_wr)
    begin
      prefix_src_bank <= (reg_wr_index == acc_prefix_pkg::PFX_IDX_SRC_HI);
      prefix_dst_bank <= (reg_wr_index == acc_prefix_pkg::PFX_IDX_DST_HI);
    end
    else
    begin
      prefix_src_bank <= 1'b0;
      prefix_dst_bank <= 1'b0;
    end
  end

  // ==========================================================
  // read port, answers one cycle after the strobe
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rd_data <= acc_prefix_pkg::READ_UNMAPPED;
    else if (reg_rd && reg_rd_module == acc_prefix_pkg::ACC_MODULE)
      reg_rd_data <= 16'(bank_bus.rd_data);
    else if (reg_rd && reg_rd_module == acc_prefix_pkg::PREFIX_MODULE)
      reg_rd_data <= instruction_prefix_word;
    else
      reg_rd_data <= acc_prefix_pkg::READ_UNMAPPED;
  end

  // ==========================================================
  // checks
  sequence pfx_written_s;
    pfx_wr && reg_wr_data[acc_prefix_pkg::PREFIX_USED_W-1:0] != '0;
  endsequence

  sequence pfx_quiet_s;
    !pfx_wr;
  endsequence

  sequence pfx_live_then_gone_s;
    prefix_data != '0 ##1 (prefix_data == '0 && !prefix_src_bank && !prefix_dst_bank);
  endsequence

  property one_shot_p;
    @(posedge core_clk) disable iff (!reset_n)
      pfx_written_s ##1 pfx_quiet_s |-> pfx_live_then_gone_s;
  endproperty

  prefix_once_a: assert property (one_shot_p)
    else $error("prefix data outlived the next instruction");

  prefix_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !pfx_wr |=> instruction_prefix_word == acc_prefix_pkg::PREFIX_RESET)
    else $error("prefix word not cleared after one cycle");

  prefix_low_byte_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    pfx_wr |=> prefix_data == $past(reg_wr_data[7:0])
           && instruction_prefix_word == $past(reg_wr_data))
    else $error("prefix data mismatch");

  prefix_shared_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    pfx_wr ##1 (reg_rd && reg_rd_module == acc_prefix_pkg::PREFIX_MODULE)
      |=> reg_rd_data == $past(reg_wr_data, 2))
    else $error("prefix index did not reach shared word");

  prefix_src_bank_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    pfx_wr && reg_wr_index == acc_prefix_pkg::PFX_IDX_SRC_HI
      |=> prefix_src_bank && !prefix_dst_bank)
    else $error("source bank not raised");

  prefix_dst_bank_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    pfx_wr && reg_wr_index == acc_prefix_pkg::PFX_IDX_DST_HI
      |=> !prefix_src_bank && prefix_dst_bank)
    else $error("destination bank not raised");

  prefix_plain_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    pfx_wr && reg_wr_index == acc_prefix_pkg::PFX_IDX_PLAIN
      |=> !prefix_src_bank && !prefix_dst_bank)
    else $error("plain prefix raised a bank");

  bank_default_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    pfx_wr ##1 !pfx_wr |=> !prefix_src_bank && !prefix_dst_bank)
    else $error("banks did not fall back to default");

  operand_track_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_wr && reg_wr_module == acc_prefix_pkg::ACC_MODULE && reg_wr_index == accumulator_selector
      |=> alu_operand == $past(reg_wr_data[DATA_W-1:0]))
    else $error("operand does not follow selected accumulator");
endmodule // accumulator_prefix_registers

//--- test/accumulator_prefix_registers_tb.sv
// Purpose: self-checking bench of the accumulator and prefix register block
// Assumes: wide variant, core model as the only requester
// Notes:   checks follow one call after the request they judge
`timescale 1ns/10ps
module accumulator_prefix_registers_tb;
  localparam logic [3:0] am = acc_prefix_pkg::ACC_MODULE;
  localparam logic [3:0] pm = acc_prefix_pkg::PREFIX_MODULE;
  logic        core_clk, reset_n, reg_wr, reg_rd, alu_result_valid, prefix_src_bank, prefix_dst_bank;
  logic [3:0]  reg_wr_module, reg_wr_index, reg_rd_module, reg_rd_index, accumulator_selector;
  logic [15:0] reg_wr_data, alu_result, reg_rd_data, alu_operand, e;
  logic [7:0]  prefix_data;
  int          errors, cmp_count, cycles;

  accumulator_prefix_registers #(.DATA_W(16)) accumulator_prefix_registers_i (.core_clk, .reset_n,
    .reg_wr, .reg_wr_module, .reg_wr_index, .reg_wr_data, .reg_rd, .reg_rd_module, .reg_rd_index,
    .reg_rd_data, .accumulator_selector, .alu_result_valid, .alu_result, .alu_operand, .prefix_data,
    .prefix_src_bank, .prefix_dst_bank);
  core_model core_model_i (.core_clk, .reg_wr, .reg_wr_module, .reg_wr_index, .reg_wr_data, .reg_rd,
    .reg_rd_module, .reg_rd_index, .reg_rd_data, .accumulator_selector, .alu_result_valid,
    .alu_result, .alu_operand, .prefix_data, .prefix_src_bank, .prefix_dst_bank);

  // ==========================================================
  // clock, timeout and shared tasks
  initial
  begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] m, input logic [3:0] i, input logic [15:0] d);
    core_model_i.cyc(1'h1, m, i, d, 1'h0, '0, '0, 1'h0, '0, '0);
  endtask
  task automatic rd(input logic [3:0] m, input logic [3:0] i);
    core_model_i.cyc(1'h0, '0, '0, '0, 1'h1, m, i, 1'h0, '0, '0);
  endtask
  task automatic nop();
    core_model_i.cyc(1'h0, '0, '0, '0, 1'h0, '0, '0, 1'h0, '0, '0);
  endtask
  // back-to-back reads of every accumulator
  task automatic acc_all(input bit zero);
    for (int i = 0; i < 16; i++)
    begin
      rd(am, 4'(i));
      if (i > 0)
        chk("acc", core_model_i.rd_q, zero ? 16'h0000 : 16'hc000 | 16'(i - 1) * 16'h0101);
    end
    nop();
    chk("acc15", core_model_i.rd_q, zero ? 16'h0000 : 16'hcf0f);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_acc();
    for (int i = 0; i < 16; i++)
      wr(am, 4'(i), 16'hc000 | 16'(i) * 16'h0101);
    wr(4'h3, 4'h0, 16'hffff);
    acc_all(1'b0);
    rd(4'h3, 4'h0);
    nop();
    chk("unmapped", core_model_i.rd_q, 16'h0000);
  endtask
  task automatic t_alu();
    core_model_i.cyc(1'h0, '0, '0, '0, 1'h0, '0, '0, 1'h1, 4'h2, 16'h0055);
    core_model_i.cyc(1'h1, am, 4'h4, 16'hbeef, 1'h0, '0, '0, 1'h1, 4'h4, 16'h1234);
    chk("alu op", core_model_i.op_q, 16'h0055);
    rd(am, 4'h2);
    chk("wr wins", core_model_i.op_q, 16'hbeef);
    nop();
    chk("alu acc", core_model_i.rd_q, 16'h0055);
  endtask
  task automatic t_pfx();
    for (int k = 0; k < 3; k++)
    begin
      wr(pm, 4'(k), 16'h12a0 | 16'(k));
      rd(pm, 4'h5);
      e = {6'h0, k == 1, k == 2, 8'ha0 | 8'(k)};
      chk("pfx live", 16'(core_model_i.pfx_q), e);
      nop();
      chk("pfx word", core_model_i.rd_q, 16'h12a0 | 16'(k));
      chk("pfx gone", 16'(core_model_i.pfx_q), 16'h0000);
    end
    wr(pm, 4'h1, 16'h1111);
    wr(pm, 4'h2, 16'h2222);
    chk("pfx first", 16'(core_model_i.pfx_q), 16'h0211);
    nop();
    chk("pfx newest", 16'(core_model_i.pfx_q), 16'h0122);
    rd(pm, 4'h0);
    chk("pfx default", 16'(core_model_i.pfx_q), 16'h0000);
    nop();
    chk("pfx read zero", core_model_i.rd_q, 16'h0000);
  endtask
  task automatic t_rst();
    wr(am, 4'h7, 16'habcd);
    wr(pm, 4'h1, 16'h5678);
    reset_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    chk("pfx in reset", {6'h0, prefix_src_bank, prefix_dst_bank, prefix_data}, 16'h0000);
    chk("op in reset", alu_operand, 16'h0000);
    chk("rd in reset", reg_rd_data, 16'h0000);
    reset_n <= 1'h1;
    acc_all(1'b1);
    chk("pfx reset", 16'(core_model_i.pfx_q), 16'h0000);
  endtask
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    reset_n = 1'h0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'h1;
    acc_all(1'b1);
    t_acc();
    t_alu();
    t_pfx();
    t_rst();
    end_sim();
  end
endmodule // accumulator_prefix_registers_tb

//--- test/core_model.sv
// Purpose: processor core model issuing register transfers and alu writeback
// Assumes: one request set per core_clk cycle, driven at the rising edge
// Notes:   each call captures what the previous call's request produced
`timescale 1ns/10ps
module core_model (
  input  wire logic        core_clk,
  output logic             reg_wr,
  output logic [3:0]       reg_wr_module,
  output logic [3:0]       reg_wr_index,
  output logic [15:0]      reg_wr_data,
  output logic             reg_rd,
  output logic [3:0]       reg_rd_module,
  output logic [3:0]       reg_rd_index,
  input  wire logic [15:0] reg_rd_data,
  output logic [3:0]       accumulator_selector,
  output logic             alu_result_valid,
  output logic [15:0]      alu_result,
  input  wire logic [15:0] alu_operand,
  input  wire logic [7:0]  prefix_data,
  input  wire logic        prefix_src_bank,
  input  wire logic        prefix_dst_bank
);
  logic [15:0] rd_q;
  logic [15:0] op_q;
  logic [9:0]  pfx_q;
  initial
  begin
    {reg_wr, reg_wr_module, reg_wr_index, reg_wr_data, reg_rd} = '0;
    {reg_rd_module, reg_rd_index, accumulator_selector, alu_result_valid, alu_result} = '0;
  end
  // ==========================================================
  // one request cycle; strobes stay as set until the next call
  task automatic cyc(input logic w, input logic [3:0] wm, input logic [3:0] wi, input logic [15:0] wd,
                     input logic r, input logic [3:0] rm, input logic [3:0] ri,
                     input logic a, input logic [3:0] s, input logic [15:0] v);
    reg_wr               <= w;
    reg_wr_module        <= wm;
    reg_wr_index         <= wi;
    reg_wr_data          <= wd;
    reg_rd               <= r;
    reg_rd_module        <= rm;
    reg_rd_index         <= ri;
    alu_result_valid     <= a;
    accumulator_selector <= s;
    alu_result           <= v;
    @(negedge core_clk);
    rd_q  = reg_rd_data;
    op_q  = alu_operand;
    pfx_q = {prefix_src_bank, prefix_dst_bank, prefix_data};
    @(posedge core_clk);
  endtask
endmodule // core_model
